// ---- verilog/prc_pkg.sv ----
// Shared constants, types and register layout of the power mode and reset controller
package prc_pkg;

  // Register bus geometry and byte offsets
  localparam int unsigned PRC_ADDR_W = 8;
  localparam logic [7:0] PRC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PRC_OFS_OPT = 8'h04;
  localparam logic [7:0] PRC_OFS_STAT = 8'h08;

  // Control register bit positions
  localparam int unsigned PRC_CTRL_SLEEP = 0;
  localparam int unsigned PRC_CTRL_ARM = 1;
  localparam int unsigned PRC_CTRL_OSCDIS = 2;

  // Option register field positions
  localparam int unsigned PRC_OPT_LO_LSB = 0;
  localparam int unsigned PRC_OPT_HI_LSB = 8;
  localparam logic [1:0] PRC_STROBE_RESET = 2'h0;

  // Bus responses
  localparam logic [1:0] PRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PRC_RESP_SLVERR = 2'h2;

  // Timing: figures in their own units, cycle counts derived from the clock rate
  localparam int unsigned PRC_CLK_MHZ = 200;
  localparam int unsigned PRC_WAKE_MIN_NS = 10000;
  localparam int unsigned PRC_WAKE_CYC = (PRC_WAKE_MIN_NS * PRC_CLK_MHZ + 999) / 1000;
  localparam int unsigned PRC_DEB_MIN_US = 16000;
  localparam int unsigned PRC_DEB_CYC = PRC_DEB_MIN_US * PRC_CLK_MHZ;
  localparam int unsigned PRC_CPU_DELAY_CYC = 32768;
  localparam int unsigned PRC_SYS_STRETCH_CYC = 16;

  typedef enum logic [2:0] {
    PRC_MD_ACTIVE = 3'h1,
    PRC_MD_STANDBY = 3'h2,
    PRC_MD_SLEEP = 3'h4
  } prc_mode_t;

  // Option word, bit 0 upward: combo_select_one, combo_select_two, in-sleep, strobe select
  typedef struct packed {
    logic [1:0] strobe_output_select;
    logic port_a_reset_in_sleep;
    logic [3:0] combo_select_two;
    logic [3:0] combo_select_one;
  } prc_opt_t;

  // Reset sources, bit 5 down to bit 0
  typedef struct packed {
    logic sleep;
    logic osc;
    logic wdog;
    logic combo;
    logic pin;
    logic por;
  } prc_src_t;

  localparam prc_opt_t PRC_OPT_RST = 11'h000;
  localparam prc_src_t PRC_CAUSE_POR = 6'h01;

endpackage : prc_pkg

// ---- verilog/prc_power_reset_ctrl.sv ----
// Operating mode control and reset combiner with AXI4-Lite register access
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Level persistence filter: hit rises after N consecutive enabled cycles of level
module prc_persist #(
  parameter int unsigned N = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic level,
  output logic hit
);
  logic [31:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 32'h0;
      hit <= 1'b0;
    end else if (ce) begin
      if (!level) begin
        cnt <= 32'h0;
      end else if (cnt != N) begin
        cnt <= cnt + 32'h1;
      end
      hit <= level && (cnt >= N - 32'h1);
    end
  end
endmodule : prc_persist

// Behaviour
// - Halt request moves active to standby; instruction execution stops, rest keeps running.
// - Standby ends on any reset or an enabled interrupt request.
// - Sleep write takes effect only if sleep_arm was already one.
// - Sleep stops oscillator, resets logic, keeps option registers.
// - Sleep ends only by long reset pin high or enabled port A combination.
// - Reset held through sleep and start-up; wake keeps sleep_arm.
// - sleep_arm reads zero after power-up, one after wake.
// - In sleep port A inputs and pulls off unless in-sleep option; port B high-Z.
// - Voltage detector finishes ongoing measure in standby, then stops; off in sleep.
// - Every reset source asserts both system and CPU reset.
// - System reset stretched fixed cycles; CPU reset held until oscillator stable.
// - Only power-on reset clears option registers and sleep_arm.
// - Strobe select zero drives reset state onto strobe output.
// - Oscillator loss in active or standby raises system reset.
// - Oscillation detection inhibited during CPU delay after wake.
// - osc_supervisor_disable inhibits detection; power-up and system reset clear it.
// - CPU reset delay lasts exactly 32768 clock cycles after release.
// - Reset pin debounced; accepted after 16 ms persistence.
// - Port A matching programmed combination generates a reset.
// - Awake, port A combination must persist 16 ms before acceptance.
// - Asleep with in-sleep option, combination resets immediately without debounce.
// - Two bits per input select never, level, inverted, always; AND or OR.
module prc_power_reset_ctrl
  import prc_pkg::*;
#(
  parameter int unsigned SYS_STRETCH = prc_pkg::PRC_SYS_STRETCH_CYC,
  parameter int unsigned CPU_DELAY = prc_pkg::PRC_CPU_DELAY_CYC,
  parameter int unsigned DEB_CYC = prc_pkg::PRC_DEB_CYC,
  parameter int unsigned WAKE_CYC = prc_pkg::PRC_WAKE_CYC,
  parameter bit COMBO_OR = 1'b0
) (
  // Clock, power-on reset, clock enable
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  // AXI4-Lite write channels
  input wire logic [prc_pkg::PRC_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [prc_pkg::PRC_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // CPU core and peripheral events
  input wire logic HALT_REQ,
  input wire logic IRQ_PEND,
  input wire logic WDOG_EXPIRE,
  input wire logic VLD_BUSY,
  // Pins and oscillator
  input wire logic RESET_PIN,
  input wire logic [3:0] INPUT_PORT_A,
  input wire logic OSC_ALIVE,
  // Resets and mode outputs
  output logic SYS_RESET,
  output logic CPU_RESET,
  output logic CPU_RUN,
  output prc_pkg::prc_mode_t MODE,
  output logic OSC_ENABLE,
  output logic VLD_ENABLE,
  output logic PORT_A_IN_EN,
  output logic PORT_A_PULL_EN,
  output logic PORT_B_HIZ,
  output logic STROBE_OUT
);
  import prc_pkg::*;

  // Register bus state
  logic [PRC_ADDR_W-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [PRC_ADDR_W-1:0] raddr_w;

  // Software-visible state
  logic sleep_arm;
  logic osc_supervisor_disable;
  prc_opt_t opt;
  prc_src_t cause;

  // Sequencing state
  logic [31:0] sys_cnt;
  logic [31:0] cpu_cnt;
  logic wake_start;

  // Bus decode
  wire wr_fire = CE && !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  wire [7:0] waddr_al = {waddr[7:2], 2'b00};
  wire wr_ctrl = wr_fire && (waddr_al == PRC_OFS_CTRL) && wstrb[0];
  wire wr_opt = wr_fire && (waddr_al == PRC_OFS_OPT);
  wire wr_bad = (waddr_al != PRC_OFS_CTRL) && (waddr_al != PRC_OFS_OPT)
                && (waddr_al != PRC_OFS_STAT);
  wire rd_fire = CE && S_AXI_ARVALID && S_AXI_ARREADY;
  assign raddr_w = {S_AXI_ARADDR[7:2], 2'b00};
  wire awake = (MODE != PRC_MD_SLEEP);

  // Port A combination terms
  logic [3:0] terms;
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_term
      assign terms[n] = opt.combo_select_one[n]
                        ? (opt.combo_select_two[n] ? 1'b1 : !INPUT_PORT_A[n])
                        : (opt.combo_select_two[n] && INPUT_PORT_A[n]);
    end
  endgenerate
  wire pa_live = awake || opt.port_a_reset_in_sleep;
  wire combo_now = pa_live && (COMBO_OR ? |terms : &terms);

  // Filters: awake debouncers and the sleep wake filter
  logic pin_hit;
  logic combo_hit;
  logic wake_pin_hit;
  prc_persist #(.N(DEB_CYC)) u_pin_deb (
    .clk(CLK_SYS), .rst_n(RSTN), .ce(CE),
    .level(awake && RESET_PIN), .hit(pin_hit));
  prc_persist #(.N(DEB_CYC)) u_combo_deb (
    .clk(CLK_SYS), .rst_n(RSTN), .ce(CE),
    .level(awake && combo_now), .hit(combo_hit));
  prc_persist #(.N(WAKE_CYC)) u_wake_flt (
    .clk(CLK_SYS), .rst_n(RSTN), .ce(CE),
    .level(!awake && RESET_PIN), .hit(wake_pin_hit));

  // Reset sources
  wire osc_watch = !osc_supervisor_disable && !wake_start;
  wire sleep_go = wr_ctrl && wdata[PRC_CTRL_SLEEP] && sleep_arm && awake;
  prc_src_t src;
  assign src.por = 1'b0;
  assign src.pin = awake && pin_hit;
  assign src.combo = awake && combo_hit;
  assign src.wdog = awake && WDOG_EXPIRE;
  assign src.osc = awake && osc_watch && !OSC_ALIVE;
  assign src.sleep = sleep_go;
  wire wake = !awake && (wake_pin_hit
              || (opt.port_a_reset_in_sleep && combo_now));
  wire any_rst = (|src) || wake;

  // Mode sequencing
  wire prc_mode_t next_mode = sleep_go ? PRC_MD_SLEEP
    : ((|src) || wake) ? PRC_MD_ACTIVE
    : (MODE == PRC_MD_ACTIVE && HALT_REQ && !CPU_RESET) ? PRC_MD_STANDBY
    : (MODE == PRC_MD_STANDBY && IRQ_PEND) ? PRC_MD_ACTIVE
    : MODE;
  wire next_awake = (next_mode != PRC_MD_SLEEP);

  // System reset stretch, held through sleep
  wire [31:0] next_sys_cnt = any_rst ? SYS_STRETCH
    : !awake ? sys_cnt
    : (sys_cnt != 32'h0) ? sys_cnt - 32'h1 : 32'h0;
  wire next_sys_reset = (next_sys_cnt != 32'h0) || !next_awake;

  // CPU reset delay, reloaded while oscillator is down or system reset is on
  wire cpu_load = SYS_RESET || any_rst || !awake || !OSC_ALIVE;
  wire [31:0] next_cpu_cnt = cpu_load ? CPU_DELAY
    : (cpu_cnt != 32'h0) ? cpu_cnt - 32'h1 : 32'h0;
  wire next_cpu_reset = (next_cpu_cnt != 32'h0) || next_sys_reset;
  wire next_wake_start = wake || (wake_start && next_cpu_reset);

  // Register updates
  wire next_osc_dis = next_sys_reset ? 1'b0
    : wr_ctrl ? wdata[PRC_CTRL_OSCDIS] : osc_supervisor_disable;
  wire next_arm = wr_ctrl ? wdata[PRC_CTRL_ARM] : sleep_arm;
  wire [10:0] next_opt_word = {
    (wr_opt && wstrb[1]) ? wdata[PRC_OPT_HI_LSB +: 3] : opt[10:8],
    (wr_opt && wstrb[0]) ? wdata[PRC_OPT_LO_LSB +: 8] : opt[7:0]};
  wire prc_opt_t next_opt = next_opt_word;
  wire prc_src_t next_cause = (|src) ? src : cause;

  // Voltage detector keeps running in standby only while a measure is under way
  wire next_vld = (next_mode == PRC_MD_ACTIVE)
    || (next_mode == PRC_MD_STANDBY && VLD_ENABLE && VLD_BUSY);

  // Read data mux
  wire [31:0] ctrl_word = {29'h0, osc_supervisor_disable, sleep_arm, !awake};
  wire [31:0] stat_word = {21'h0, cause, CPU_RESET, SYS_RESET, MODE};
  wire rd_bad = (raddr_w != PRC_OFS_CTRL) && (raddr_w != PRC_OFS_OPT)
                && (raddr_w != PRC_OFS_STAT);
  wire [31:0] rd_word = (raddr_w == PRC_OFS_CTRL) ? ctrl_word
    : (raddr_w == PRC_OFS_OPT) ? {21'h0, opt}
    : (raddr_w == PRC_OFS_STAT) ? stat_word : 32'h0;

  // Option registers and sleep_arm: cleared by power-on reset only
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      opt <= PRC_OPT_RST;
      sleep_arm <= 1'b0;
      cause <= PRC_CAUSE_POR;
    end else if (CE) begin
      opt <= next_opt;
      sleep_arm <= next_arm;
      cause <= next_cause;
    end
  end

  // Mode, reset sequencing and pin controls
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      MODE <= PRC_MD_ACTIVE;
      sys_cnt <= SYS_STRETCH;
      cpu_cnt <= CPU_DELAY;
      wake_start <= 1'b0;
      osc_supervisor_disable <= 1'b0;
      SYS_RESET <= 1'b1;
      CPU_RESET <= 1'b1;
      CPU_RUN <= 1'b0;
      OSC_ENABLE <= 1'b1;
      VLD_ENABLE <= 1'b1;
      PORT_A_IN_EN <= 1'b1;
      PORT_A_PULL_EN <= 1'b1;
      PORT_B_HIZ <= 1'b0;
      STROBE_OUT <= 1'b1;
    end else if (CE) begin
      MODE <= next_mode;
      sys_cnt <= next_sys_cnt;
      cpu_cnt <= next_cpu_cnt;
      wake_start <= next_wake_start;
      osc_supervisor_disable <= next_osc_dis;
      SYS_RESET <= next_sys_reset;
      CPU_RESET <= next_cpu_reset;
      CPU_RUN <= (next_mode == PRC_MD_ACTIVE) && !next_cpu_reset;
      OSC_ENABLE <= next_awake;
      VLD_ENABLE <= next_vld;
      PORT_A_IN_EN <= next_awake || next_opt.port_a_reset_in_sleep;
      PORT_A_PULL_EN <= next_awake || next_opt.port_a_reset_in_sleep;
      PORT_B_HIZ <= !next_awake;
      STROBE_OUT <= (next_opt.strobe_output_select == PRC_STROBE_RESET)
                    && next_cpu_reset;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= PRC_RESP_OKAY;
      waddr <= '0;
      wdata <= 32'h0;
      wstrb <= 4'h0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        waddr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wdata <= S_AXI_WDATA;
        wstrb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_bad ? PRC_RESP_SLVERR : PRC_RESP_OKAY;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= PRC_RESP_OKAY;
    end else if (CE) begin
      if (rd_fire) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_bad ? PRC_RESP_SLVERR : PRC_RESP_OKAY;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // Helper: cycles of CPU reset after system reset release with a running oscillator
  logic [31:0] hold_cnt;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      hold_cnt <= 32'h0;
    end else if (SYS_RESET || !OSC_ALIVE) begin
      hold_cnt <= 32'h0;
    end else if (CE && CPU_RESET) begin
      hold_cnt <= hold_cnt + 32'h1;
    end
  end

  sequence s_halt_ok;
    CE && MODE == PRC_MD_ACTIVE && HALT_REQ && !CPU_RESET && !any_rst && !sleep_go;
  endsequence
  sequence s_in_standby;
    MODE == PRC_MD_STANDBY && !CPU_RUN;
  endsequence
  property p_halt;
    s_halt_ok |=> s_in_standby;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not enter standby");

  property p_standby_exit;
    CE && MODE == PRC_MD_STANDBY && IRQ_PEND && !sleep_go |=> MODE == PRC_MD_ACTIVE;
  endproperty
  a_standby_exit: assert property (p_standby_exit) else $error("standby not left");

  property p_sleep_gate;
    CE && wr_ctrl && wdata[PRC_CTRL_SLEEP] && !sleep_arm && awake |=> MODE != PRC_MD_SLEEP;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep without arm");

  sequence s_asleep;
    MODE == PRC_MD_SLEEP && SYS_RESET && !OSC_ENABLE && PORT_B_HIZ;
  endsequence
  property p_sleep_enter;
    sleep_go |=> s_asleep ##1 (SYS_RESET && CPU_RESET);
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry wrong");

  property p_wake_arm;
    CE && wake && !wr_ctrl |=> MODE == PRC_MD_ACTIVE && sleep_arm && SYS_RESET && CPU_RESET;
  endproperty
  a_wake_arm: assert property (p_wake_arm) else $error("wake lost arm or reset");

  property p_wdog_reset;
    CE && awake && WDOG_EXPIRE |=> SYS_RESET && CPU_RESET && cause.wdog;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog reset missing");

  property p_cpu_delay;
    $fell(CPU_RESET) && $past(OSC_ALIVE) |-> hold_cnt == CPU_DELAY;
  endproperty
  a_cpu_delay: assert property (p_cpu_delay) else $error("CPU delay length wrong");

  property p_strobe;
    opt.strobe_output_select == PRC_STROBE_RESET && $stable(opt) |-> STROBE_OUT == CPU_RESET;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not showing reset");

  property p_osc_loss;
    CE && awake && osc_watch && !OSC_ALIVE |=> SYS_RESET ##1 CPU_RESET;
  endproperty
  a_osc_loss: assert property (p_osc_loss) else $error("oscillator loss ignored");

  property p_osc_dis_clear;
    SYS_RESET |-> !osc_supervisor_disable;
  endproperty
  a_osc_dis_clear: assert property (p_osc_dis_clear) else $error("disable kept");

  property p_combo_sleep;
    CE && !awake && opt.port_a_reset_in_sleep && combo_now |=> MODE == PRC_MD_ACTIVE;
  endproperty
  a_combo_sleep: assert property (p_combo_sleep) else $error("combo wake missed");

endmodule : prc_power_reset_ctrl

// ---- verification/prc_far_model.sv ----
// Far-side model: CPU core, reset pin, port A pins and crystal oscillator
`timescale 1ns/1ps
module prc_far_model
  import prc_pkg::*;
(
  // Bench commands
  input wire logic halt_cmd,
  input wire logic irq_cmd,
  input wire logic wdog_cmd,
  input wire logic vld_cmd,
  input wire logic osc_kill,
  input wire logic pin_cmd,
  input wire logic [3:0] pa_cmd,
  // Device outputs seen by the far side
  input wire logic cpu_run,
  input wire logic osc_enable,
  input wire logic vld_enable,
  // Device inputs
  output logic halt_req,
  output logic irq_pend,
  output logic wdog_expire,
  output logic vld_busy,
  output logic reset_pin,
  output logic [3:0] port_a,
  output logic osc_alive
);
  // Only a running core can execute a halt
  assign halt_req = halt_cmd & cpu_run;
  assign irq_pend = irq_cmd;
  assign wdog_expire = wdog_cmd;
  // A measure only runs while the detector is enabled
  assign vld_busy = vld_cmd & vld_enable;
  assign reset_pin = pin_cmd;
  assign port_a = pa_cmd;
  // Crystal stops whenever the device disables it
  assign osc_alive = osc_enable & ~osc_kill;
endmodule : prc_far_model

// ---- verification/prc_power_reset_ctrl_tb.sv ----
// Self-checking bench of the power mode and reset controller
`timescale 1ns/1ps
module prc_power_reset_ctrl_tb;
  import prc_pkg::*;
  localparam int unsigned CPUD = 20;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'h0, wv = 1'h0, arv = 1'h0;
  logic halt = 1'h0, irq = 1'h0, wdog = 1'h0, vld = 1'h0, okill = 1'h0, pin = 1'h0;
  logic [3:0] pa = 4'h0;
  logic [1:0] strb = 2'h0;
  logic ce = 1'h1, brdy = 1'h1, rrdy = 1'h1;
  logic [3:0] ws = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, sys_rst, cpu_rst, cpu_run, strobe;
  logic osc_en, vld_en, pa_in, pa_pull, pb_hiz, halt_req, irq_pend, wdog_exp, vld_busy;
  logic reset_pin, osc_alive;
  logic [3:0] port_a;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  prc_mode_t mode;
  int err_total = 0;
  int cmp_count = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];

  always #2.5 clk_sys = ~clk_sys;

  prc_power_reset_ctrl #(.SYS_STRETCH(4), .CPU_DELAY(CPUD), .DEB_CYC(8), .WAKE_CYC(5))
    prc_power_reset_ctrl_inst (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(brdy),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rrdy),
    .HALT_REQ(halt_req), .IRQ_PEND(irq_pend), .WDOG_EXPIRE(wdog_exp), .VLD_BUSY(vld_busy),
    .RESET_PIN(reset_pin), .INPUT_PORT_A(port_a), .OSC_ALIVE(osc_alive),
    .SYS_RESET(sys_rst), .CPU_RESET(cpu_rst), .CPU_RUN(cpu_run), .MODE(mode),
    .OSC_ENABLE(osc_en), .VLD_ENABLE(vld_en), .PORT_A_IN_EN(pa_in),
    .PORT_A_PULL_EN(pa_pull), .PORT_B_HIZ(pb_hiz), .STROBE_OUT(strobe));

  prc_far_model prc_far_model_inst (
    .halt_cmd(halt), .irq_cmd(irq), .wdog_cmd(wdog), .vld_cmd(vld), .osc_kill(okill),
    .pin_cmd(pin), .pa_cmd(pa), .cpu_run(cpu_run), .osc_enable(osc_en),
    .vld_enable(vld_en), .halt_req(halt_req), .irq_pend(irq_pend),
    .wdog_expire(wdog_exp), .vld_busy(vld_busy), .reset_pin(reset_pin),
    .port_a(port_a), .osc_alive(osc_alive));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic lim_hit;
    chk(34'h1, 34'h0, "wait limit");
    give_verdict();
  endtask : lim_hit

  function automatic logic pick(input int w);
    case (w)
      0: return sys_rst;
      1: return cpu_rst;
      default: return mode === PRC_MD_SLEEP;
    endcase
  endfunction : pick

  task automatic waitv(input int w, input logic v, input int lim, output int n);
    for (n = 0; n < lim && pick(w) !== v; n++) @(posedge clk_sys);
    if (n == lim) lim_hit();
  endtask : waitv

  // Bus results are compared in order of issue
  always @(posedge clk_sys) begin
    if (bvalid === 1'h1 && brdy === 1'h1) chk(bresp, bq.pop_front(), "write response");
    if (rvalid === 1'h1 && rrdy === 1'h1) chk({rresp, rdata}, rq.pop_front(), "read data");
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      if (awready) awv <= 1'h0;
      if (wready) wv <= 1'h0;
      n++;
    end while (n < 50 && !(bvalid === 1'h1 && !awv && !wv));
    if (n == 50) lim_hit();
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arv <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      if (arready) arv <= 1'h0;
      n++;
    end while (n < 50 && !(rvalid === 1'h1 && !arv));
    if (n == 50) lim_hit();
  endtask : axr

  // Follows one reset from its start until the core runs again
  task automatic settle(input bit exact);
    int n;
    chk({sys_rst, cpu_rst, cpu_run}, 3'h6, "reset outputs");
    chk(strobe, strb == 2'h0 ? cpu_rst : 1'h0, "strobe");
    waitv(0, 1'h0, 300, n);
    waitv(1, 1'h0, 300, n);
    if (exact) chk(n, CPUD, "cpu delay");
    chk({mode, cpu_run, strobe}, {PRC_MD_ACTIVE, 2'h2}, "resumed");
  endtask : settle

  initial begin
    int i;
    int k;
    int n;
    logic e;
    logic [3:0] s1;
    logic [3:0] s2;
    void'($urandom(16715));
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    settle(1'h1);
    axr(PRC_OFS_STAT, 32'h21, PRC_RESP_OKAY);
    axw(PRC_OFS_STAT, 32'hFFFF, PRC_RESP_OKAY);
    axr(PRC_OFS_STAT, 32'h21, PRC_RESP_OKAY);
    axr(8'h0C, 32'h0, PRC_RESP_SLVERR);
    axw(8'h10, 32'h1, PRC_RESP_SLVERR);
    axr(PRC_OFS_CTRL, 32'h0, PRC_RESP_OKAY);
    // Control write with its low byte lane off must not arm sleep
    ws <= 4'hE;
    axw(PRC_OFS_CTRL, 32'h2, PRC_RESP_OKAY);
    ws <= 4'hF;
    axr(PRC_OFS_CTRL, 32'h0, PRC_RESP_OKAY);
    $display("test registers done");
    axw(PRC_OFS_CTRL, 32'h1, PRC_RESP_OKAY);
    @(posedge clk_sys);
    chk(mode, PRC_MD_ACTIVE, "unarmed sleep");
    strb = 2'($urandom_range(3, 1));
    s2 = 4'($urandom);
    axw(PRC_OFS_OPT, {strb, 1'h0, s2, 4'h0}, PRC_RESP_OKAY);
    axw(PRC_OFS_CTRL, 32'h2, PRC_RESP_OKAY);
    axw(PRC_OFS_CTRL, 32'h3, PRC_RESP_OKAY);
    @(posedge clk_sys);
    chk({mode, osc_en, vld_en, pa_in, pa_pull, pb_hiz, sys_rst, strobe},
      {PRC_MD_SLEEP, 7'h06}, "sleep outputs");
    pin <= 1'h1;
    repeat (4) @(posedge clk_sys);
    pin <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk(mode, PRC_MD_SLEEP, "short pin pulse");
    pin <= 1'h1;
    waitv(2, 1'h0, 12, n);
    pin <= 1'h0;
    settle(1'h1);
    axr(PRC_OFS_CTRL, 32'h2, PRC_RESP_OKAY);
    axr(PRC_OFS_OPT, {strb, 1'h0, s2, 4'h0}, PRC_RESP_OKAY);
    $display("test sleep by pin done");
    vld <= 1'h1;
    halt <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk({mode, cpu_run, vld_en}, {PRC_MD_STANDBY, 2'h1}, "standby");
    halt <= 1'h0;
    vld <= 1'h0;
    repeat (3) @(posedge clk_sys);
    chk(vld_en, 1'h0, "detector stop");
    irq <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk({mode, cpu_run}, {PRC_MD_ACTIVE, 1'h1}, "standby exit");
    irq <= 1'h0;
    pin <= 1'h1;
    repeat (7) @(posedge clk_sys);
    chk(sys_rst, 1'h0, "pin noise");
    waitv(0, 1'h1, 5, n);
    pin <= 1'h0;
    settle(1'h1);
    axr(PRC_OFS_CTRL, 32'h2, PRC_RESP_OKAY);
    $display("test standby and pin done");
    axw(PRC_OFS_CTRL, 32'h6, PRC_RESP_OKAY);
    okill <= 1'h1;
    repeat (6) @(posedge clk_sys);
    chk(sys_rst, 1'h0, "detector disabled");
    okill <= 1'h0;
    waitv(1, 1'h0, 100, n);
    // Enable low freezes everything, a watchdog request included
    ce <= 1'h0;
    wdog <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk({sys_rst, mode}, {1'h0, PRC_MD_ACTIVE}, "frozen by enable");
    ce <= 1'h1;
    @(posedge clk_sys);
    wdog <= 1'h0;
    @(posedge clk_sys);
    settle(1'h1);
    axr(PRC_OFS_CTRL, 32'h2, PRC_RESP_OKAY);
    okill <= 1'h1;
    waitv(0, 1'h1, 5, n);
    okill <= 1'h0;
    settle(1'h0);
    $display("test watchdog and oscillator done");
    strb = 2'h0;
    for (i = 0; i < 6; i++) begin
      s1 = i == 0 ? 4'hC : i == 1 ? 4'h0 : 4'($urandom);
      s2 = i == 0 ? 4'hA : i == 1 ? 4'hF : 4'($urandom);
      pa <= i == 1 ? 4'hF : 4'($urandom);
      axw(PRC_OFS_OPT, {7'h00, s2, s1}, PRC_RESP_OKAY);
      e = 1'h1;
      for (k = 0; k < 4; k++) begin
        e &= {s1[k], s2[k]} == 2'h1 ? pa[k] : {s1[k], s2[k]} == 2'h2 ? ~pa[k] : s1[k] & s2[k];
      end
      repeat (12) @(posedge clk_sys);
      chk(sys_rst, e, "port combination");
      axw(PRC_OFS_OPT, 32'h0, PRC_RESP_OKAY);
      if (e) settle(1'h1);
    end
    pa <= 4'h0;
    $display("test port combination done");
    axw(PRC_OFS_OPT, 32'h1F0, PRC_RESP_OKAY);
    axw(PRC_OFS_CTRL, 32'h3, PRC_RESP_OKAY);
    @(posedge clk_sys);
    chk({mode, osc_en, vld_en, pa_in, pa_pull, pb_hiz, sys_rst, strobe},
      {PRC_MD_SLEEP, 7'h1F}, "sleep with port wake");
    pa <= 4'hF;
    waitv(2, 1'h0, 4, n);
    pa <= 4'h0;
    settle(1'h1);
    $display("test port wake done");
    // Second power-on clears options and the arm latch
    rstn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    settle(1'h1);
    axr(PRC_OFS_CTRL, 32'h0, PRC_RESP_OKAY);
    axr(PRC_OFS_OPT, 32'h0, PRC_RESP_OKAY);
    axr(PRC_OFS_STAT, 32'h21, PRC_RESP_OKAY);
    $display("test second power-on done");
    give_verdict();
  end
endmodule : prc_power_reset_ctrl_tb
